// >>> core/aks_selector.sv
// Address key selector: per-level key registers, active key choice, protect check.
// Assumes requests, instructions and interrupts come from logic on clk_sys,
// and that the translator returns the read-only bit of the selected segment
// register in the same cycle as the request.
`timescale 1ns/1ps

module aks_selector
   import aks_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // Avalon-MM slave
   input  wire logic [AKS_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   // System events
   input  wire logic                  initial_program_load,
   input  wire logic                  supervisor,
   input  wire logic [AKS_LVL_W-1:0]  cur_level,
   input  wire logic                  en_instr,
   input  wire logic                  en_merge,
   input  wire logic                  translator_off_instr,
   input  wire aks_irq_t              irq_in,
   // Access path
   input  wire aks_req_t              req_in,
   input  wire logic                  seg_read_only,
   output aks_out_t                   acc_out,
   output logic                       protect_check,
   output logic      [AKS_KEY_W-1:0]  stop_cmp_key,
   output logic                       stop_cmp_keyed,
   output logic                       xlate_enabled
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      aks_bus_t                        bus_st;      // Bus handshake phase
      logic [AKS_LEVELS-1:0][15:0]     lkr;         // Level key registers
      logic [AKS_KEY_W-1:0]            console_key; // Console storage-address key
      logic [AKS_KEY_W-1:0]            stop_key;    // Stop-compare key
      logic                            xlate_en;    // Translator enabled
      logic [AKS_KEY_W-1:0]            last_key;    // Last processor active key
      logic                            prot_flag;   // Sticky protect indicator
      logic [31:0]                     rdata;       // Registered read data
   } aks_state_t;

   aks_state_t st_reg;    // Registered state
   aks_state_t st_next;   // Next state

   // ************************************************************
   // Field helpers
   // ************************************************************
   function automatic logic [AKS_KEY_W-1:0] f_op1(input logic [15:0] w);
      f_op1 = w[AKS_OP1_LSB +: AKS_KEY_W];
   endfunction : f_op1

   function automatic logic [AKS_KEY_W-1:0] f_op2(input logic [15:0] w);
      f_op2 = w[AKS_OP2_LSB +: AKS_KEY_W];
   endfunction : f_op2

   function automatic logic [AKS_KEY_W-1:0] f_isk(input logic [15:0] w);
      f_isk = w[AKS_ISK_LSB +: AKS_KEY_W];
   endfunction : f_isk

   // Only defined fields are stored; reserved bits read zero
   function automatic logic [15:0] f_pack(input logic m, input logic [2:0] k1,
                                          input logic [2:0] k2, input logic [2:0] ki);
      logic [15:0] w;
      w                            = 16'h0000;
      w[AKS_MERGE_POS]             = m;
      w[AKS_OP1_LSB +: AKS_KEY_W]  = k1;
      w[AKS_OP2_LSB +: AKS_KEY_W]  = k2;
      w[AKS_ISK_LSB +: AKS_KEY_W]  = ki;
      f_pack = w;
   endfunction : f_pack

   // Active key for one access type
   function automatic logic [AKS_KEY_W-1:0] f_sel(input aks_acc_t a, input logic [15:0] w,
                                                  input logic [2:0] csk, input logic [2:0] conk);
      case (a)
         ACC_IFETCH:    f_sel = f_isk(w);
         ACC_EXT_WORD,
         ACC_BR_INDIR:  f_sel = f_isk(w);
         ACC_OP1:       f_sel = w[AKS_MERGE_POS] ? f_op2(w) : f_op1(w);
         ACC_OP2:       f_sel = f_op2(w);
         ACC_DPC_WRITE: f_sel = f_op2(w);
         ACC_CS_DATA:   f_sel = csk;
         ACC_DCB_FETCH: f_sel = AKS_KEY_ZERO;
         ACC_CONSOLE:   f_sel = conk;
         ACC_LSB_STORE: f_sel = AKS_KEY_ZERO;
         default:       f_sel = AKS_KEY_ZERO;
      endcase
   endfunction : f_sel

   // ************************************************************
   // Access path, combinational for zero added latency
   // ************************************************************
   logic [AKS_KEY_W-1:0] act_key;   // Chosen key
   logic                 is_cs;     // Access made by a cycle-steal channel
   logic                 is_proc;   // Access made by the processor

   // Key choice and protect check
   always_comb begin
      act_key = f_sel(req_in.acc, st_reg.lkr[req_in.level], req_in.cs_key,
                      st_reg.console_key);
      is_cs   = (req_in.acc == ACC_CS_DATA) || (req_in.acc == ACC_DCB_FETCH);
      is_proc = !is_cs && (req_in.acc != ACC_CONSOLE);
      // Read-only bit counts only for problem-state processor and console writes
      protect_check = req_in.valid && req_in.write && st_reg.xlate_en && !supervisor
                      && !is_cs && seg_read_only;
      acc_out.valid = req_in.valid;
      acc_out.write = req_in.write && !protect_check;
      acc_out.key   = act_key;
   end

   // Stop-compare key only applies with the translator on
   assign stop_cmp_key   = st_reg.stop_key;
   assign stop_cmp_keyed = st_reg.xlate_en;
   assign xlate_enabled  = st_reg.xlate_en;

   // ************************************************************
   // Bus handshake: one wait cycle, answer in the next
   // ************************************************************
   logic bus_req;   // Any request present
   assign bus_req         = avs_read || avs_write;
   assign avs_waitrequest = bus_req && (st_reg.bus_st == BUS_IDLE);
   assign avs_readdata    = st_reg.rdata;

   // ************************************************************
   // Next state
   // ************************************************************
   logic [15:0]          wmask;     // Byte lanes being written
   logic [15:0]          old_w;     // Interrupted level before interrupt
   logic [AKS_KEY_W-1:0] new_op1;   // First-operand key after interrupt

   always_comb begin
      st_next = st_reg;
      wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      old_w   = st_reg.lkr[irq_in.level];
      new_op1 = AKS_KEY_ZERO;

      // Last processor key, needed for check interrupts
      if (req_in.valid && is_proc) begin
         st_next.last_key = act_key;
      end

      // Bus phase and register access happen on the taking edge
      case (st_reg.bus_st)
         BUS_IDLE: begin
            if (bus_req) begin
               st_next.bus_st = BUS_ACK;
               st_next.rdata  = 32'h0000_0000;
               // Level key registers: key-register instruction path
               if (avs_address < AKS_OFF_CONSOLE && avs_address[1:0] == 2'h0) begin
                  if (avs_write) begin
                     st_next.lkr[avs_address[3:2]] = f_pack(avs_writedata[AKS_MERGE_POS],
                        f_op1(avs_writedata[15:0]), f_op2(avs_writedata[15:0]),
                        f_isk(avs_writedata[15:0])) & wmask
                        | st_reg.lkr[avs_address[3:2]] & ~wmask;
                  end
                  st_next.rdata = {16'h0000, st_reg.lkr[avs_address[3:2]]};
               end else begin
                  case (avs_address)
                     AKS_OFF_CONSOLE: begin
                        if (avs_write && avs_byteenable[0]) begin
                           st_next.console_key = avs_writedata[AKS_KEY_W-1:0];
                        end
                        st_next.rdata = {29'h0000_0000, st_reg.console_key};
                     end
                     AKS_OFF_STOPCMP: begin
                        if (avs_write && avs_byteenable[0]) begin
                           st_next.stop_key = avs_writedata[AKS_KEY_W-1:0];
                        end
                        st_next.rdata = {29'h0000_0000, st_reg.stop_key};
                     end
                     AKS_OFF_STATUS: begin
                        // Write one clears the flag
                        if (avs_write && avs_byteenable[0] && avs_writedata[AKS_STAT_PROT]) begin
                           st_next.prot_flag = 1'b0;
                        end
                        st_next.rdata = {28'h000_0000, st_reg.prot_flag, st_reg.last_key};
                     end
                     AKS_OFF_CONTROL: begin
                        if (avs_write && avs_byteenable[0]) begin
                           st_next.xlate_en = avs_writedata[AKS_CTRL_XLAT];
                        end
                        st_next.rdata = {31'h0000_0000, st_reg.xlate_en};
                     end
                     // Unmapped: reads zero, writes dropped
                     default: st_next.rdata = 32'h0000_0000;
                  endcase
               end
            end
         end
         BUS_ACK: begin
            st_next.bus_st = BUS_IDLE;
         end
         default: st_next.bus_st = BUS_IDLE;
      endcase

      // Translator enable and disable instructions act on the running level
      if (en_instr) begin
         st_next.xlate_en = 1'b1;
         st_next.lkr[cur_level][AKS_MERGE_POS] = en_merge;
      end else if (translator_off_instr) begin
         st_next.xlate_en = 1'b0;
         st_next.lkr[cur_level][AKS_MERGE_POS] = 1'b0;
      end

      // Set after the clear so a new violation is never lost
      if (protect_check) begin
         st_next.prot_flag = 1'b1;
      end

      // Interrupt overrides bus writes and instructions on its level; program load overrides it
      if (irq_in.valid) begin
         case (irq_in.kind)
            INT_SVC,
            INT_SOFT_TRAP: new_op1 = f_op2(old_w);
            INT_MCHECK,
            INT_PCHECK:    new_op1 = st_reg.last_key;
            INT_TRACE:     new_op1 = f_isk(old_w);
            default:       new_op1 = AKS_KEY_ZERO;
         endcase
         st_next.lkr[irq_in.level] = f_pack(1'b0, new_op1, AKS_KEY_ZERO,
                                            AKS_KEY_ZERO);
      end

      // Program load clears every level and disables translation
      if (initial_program_load) begin
         st_next.lkr      = {AKS_LEVELS{AKS_LKR_RST}};
         st_next.xlate_en = 1'b0;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   // Synchronous reset clears keys like a system reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg.bus_st      <= BUS_IDLE;
         st_reg.lkr         <= {AKS_LEVELS{AKS_LKR_RST}};
         st_reg.console_key <= AKS_KEY_RST;
         st_reg.stop_key    <= AKS_KEY_RST;
         st_reg.xlate_en    <= 1'b0;
         st_reg.last_key    <= AKS_KEY_RST;
         st_reg.prot_flag   <= 1'b0;
         st_reg.rdata       <= 32'h0000_0000;
      end else begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic [15:0]          a_req_w;    // Key word of the requesting level
   logic [AKS_KEY_W-1:0] a_pre_op2;  // Second key before an interrupt
   logic [AKS_KEY_W-1:0] a_pre_isk;  // Instruction key before an interrupt
   assign a_req_w   = st_reg.lkr[req_in.level];
   assign a_pre_op2 = f_op2(st_reg.lkr[irq_in.level]);
   assign a_pre_isk = f_isk(st_reg.lkr[irq_in.level]);

   sequence s_bus_take;
      bus_req && st_reg.bus_st == BUS_IDLE && avs_waitrequest;
   endsequence
   sequence s_bus_answer;
      !avs_waitrequest && st_reg.bus_st == BUS_ACK;
   endsequence
   // Interrupts that leave every key of their level at zero
   sequence s_irq_plain;
      irq_in.valid && !initial_program_load && (irq_in.kind == INT_PRIORITY || irq_in.kind == INT_CONSOLE
                               || irq_in.kind == INT_POWER);
   endsequence
   // Check interrupts load the first key from the last processor key
   sequence s_irq_check;
      irq_in.valid && !initial_program_load && (irq_in.kind == INT_MCHECK || irq_in.kind == INT_PCHECK);
   endsequence
   // Enable that no interrupt or program load overrides on its level
   sequence s_xlate_on;
      en_instr && !initial_program_load && !(irq_in.valid && irq_in.level == cur_level);
   endsequence

   // Handshake and key choice
   a_bus_answer_next: assert property (s_bus_take |=> s_bus_answer)
      else $error("bus answer not in the cycle after the request");
   a_ifetch_isk: assert property (req_in.valid && req_in.acc == ACC_IFETCH
                                  |-> acc_out.key == f_isk(a_req_w))
      else $error("fetch key is not the instruction key");
   a_merge_op2: assert property (req_in.valid && req_in.acc == ACC_OP1 && a_req_w[AKS_MERGE_POS]
                                 |-> acc_out.key == f_op2(a_req_w))
      else $error("merged operand 1 does not use second key");
   a_op1_own: assert property (req_in.valid && req_in.acc == ACC_OP1 && !a_req_w[AKS_MERGE_POS]
                               |-> acc_out.key == f_op1(a_req_w))
      else $error("operand 1 does not use first key");
   a_zero_key: assert property (req_in.valid && (req_in.acc == ACC_DCB_FETCH
                                || req_in.acc == ACC_LSB_STORE) |-> acc_out.key == 3'h0)
      else $error("control block or status store not on key 0");
   a_cs_key: assert property (req_in.valid && req_in.acc == ACC_CS_DATA
                              |-> acc_out.key == req_in.cs_key)
      else $error("cycle-steal access not on its own key");
   a_dpc_op2: assert property (req_in.valid && req_in.acc == ACC_DPC_WRITE
                               |-> acc_out.key == f_op2(a_req_w))
      else $error("direct transfer not on second key");
   a_indir_isk: assert property (req_in.valid && (req_in.acc == ACC_EXT_WORD
                                 || req_in.acc == ACC_BR_INDIR) |-> acc_out.key == f_isk(a_req_w))
      else $error("indirect or extension access not on instruction key");
   a_console_key: assert property (req_in.valid && req_in.acc == ACC_CONSOLE
                                   |-> acc_out.key == st_reg.console_key)
      else $error("console access not on console key");
   a_same_cycle: assert property (acc_out.valid == req_in.valid)
      else $error("access output not in the request cycle");

   // Protect check
   a_protect_fire: assert property (req_in.valid && req_in.write && seg_read_only && st_reg.xlate_en
                                    && !supervisor && req_in.acc == ACC_OP2
                                    |-> protect_check && !acc_out.write ##1 st_reg.prot_flag)
      else $error("read-only write not checked");
   a_protect_exempt: assert property (req_in.acc == ACC_CS_DATA || supervisor |-> !protect_check)
      else $error("protect check on an exempt access");

   // Key loading by interrupts, instructions and program load
   a_irq_clear: assert property (irq_in.valid && !initial_program_load
                                 |=> !st_reg.lkr[$past(irq_in.level)][AKS_MERGE_POS]
                                 && f_op2(st_reg.lkr[$past(irq_in.level)]) == 3'h0
                                 && f_isk(st_reg.lkr[$past(irq_in.level)]) == 3'h0)
      else $error("interrupt left merge or keys set");
   a_irq_op1_zero: assert property (s_irq_plain |=> f_op1(st_reg.lkr[$past(irq_in.level)]) == 3'h0)
      else $error("first key not cleared by interrupt");
   a_svc_op1: assert property (irq_in.valid && !initial_program_load && (irq_in.kind == INT_SVC
                               || irq_in.kind == INT_SOFT_TRAP)
                               |=> f_op1(st_reg.lkr[$past(irq_in.level)]) == $past(a_pre_op2))
      else $error("call interrupt did not copy second key");
   a_check_op1: assert property (s_irq_check
                                 |=> f_op1(st_reg.lkr[$past(irq_in.level)]) == $past(st_reg.last_key))
      else $error("check interrupt did not copy last key");
   a_trace_op1: assert property (irq_in.valid && !initial_program_load && irq_in.kind == INT_TRACE
                                 |=> f_op1(st_reg.lkr[$past(irq_in.level)]) == $past(a_pre_isk))
      else $error("trace interrupt did not copy instruction key");
   a_xlate_on: assert property (s_xlate_on
                                |=> st_reg.xlate_en
                                    && st_reg.lkr[$past(cur_level)][AKS_MERGE_POS] == $past(en_merge))
      else $error("enable did not set translator and merge");
   a_ipl_clear: assert property (initial_program_load |=> st_reg.lkr == '0 && !st_reg.xlate_en)
      else $error("program load left keys set");

endmodule : aks_selector

// >>> core/aks_pkg.sv
// Constants, field layouts and carrier types for the address key selector.
// Assumes a single 20 MHz processor clock and a synchronous active-high reset.
package aks_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int AKS_KEY_W  = 3;        // Width of one address key
   localparam int AKS_LEVELS = 4;        // Priority levels, one key register each
   localparam int AKS_LVL_W  = 2;        // Width of a level number
   localparam int AKS_ADDR_W = 5;        // Avalon byte address width

   // ************************************************************
   // Level key register layout (bit 0 of the printed numbering is [15])
   // ************************************************************
   localparam int AKS_MERGE_POS = 15;    // Operand-space merge bit
   localparam int AKS_OP1_LSB   = 8;     // First-operand key [10:8]
   localparam int AKS_OP2_LSB   = 4;     // Second-operand key [6:4]
   localparam int AKS_ISK_LSB   = 0;     // Instruction-space key [2:0]
   localparam int AKS_STAT_PROT = 3;     // Sticky protect flag in status word
   localparam int AKS_CTRL_XLAT = 0;     // Translator enable in control word

   // ************************************************************
   // Register byte offsets and reset values
   // ************************************************************
   localparam logic [4:0]  AKS_OFF_LKR0    = 5'h00;   // Level n at 4*n
   localparam logic [4:0]  AKS_OFF_CONSOLE = 5'h10;   // Console storage-address key
   localparam logic [4:0]  AKS_OFF_STOPCMP = 5'h14;   // Stop-compare key
   localparam logic [4:0]  AKS_OFF_STATUS  = 5'h18;   // Last key, protect flag
   localparam logic [4:0]  AKS_OFF_CONTROL = 5'h1C;   // Translator enable
   localparam logic [15:0] AKS_LKR_RST     = 16'h0000;
   localparam logic [2:0]  AKS_KEY_RST     = 3'h0;
   localparam logic [2:0]  AKS_KEY_ZERO    = 3'h0;    // Supervisor key

   // ************************************************************
   // Enumerations
   // ************************************************************
   typedef enum logic [3:0] {
      ACC_IFETCH    = 4'h0,   // Instruction fetch
      ACC_EXT_WORD  = 4'h1,   // Instruction extension word
      ACC_BR_INDIR  = 4'h2,   // Indirect branch target
      ACC_OP1       = 4'h3,   // Operand 1 of storage-to-storage (and its EA)
      ACC_OP2       = 4'h4,   // Any other data access (and its EA)
      ACC_CS_DATA   = 4'h5,   // Cycle-steal data transfer
      ACC_DCB_FETCH = 4'h6,   // Device control block fetch
      ACC_DPC_WRITE = 4'h7,   // Direct program transfer into storage
      ACC_CONSOLE   = 4'h8,   // Console storage access
      ACC_LSB_STORE = 4'h9    // Level status block store
   } aks_acc_t;

   typedef enum logic [2:0] {
      INT_PRIORITY  = 3'h0,
      INT_SVC       = 3'h1,
      INT_MCHECK    = 3'h2,
      INT_PCHECK    = 3'h3,
      INT_SOFT_TRAP = 3'h4,
      INT_TRACE     = 3'h5,
      INT_CONSOLE   = 3'h6,
      INT_POWER     = 3'h7
   } aks_int_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,        // Waiting for a request
      BUS_ACK  = 1'b1         // Answer cycle, waitrequest low
   } aks_bus_t;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic                 valid;
      aks_acc_t             acc;
      logic                 write;
      logic [AKS_LVL_W-1:0] level;
      logic [AKS_KEY_W-1:0] cs_key;   // Key from the device control block
   } aks_req_t;

   typedef struct packed {
      logic                 valid;
      logic                 write;     // Write still allowed to proceed
      logic [AKS_KEY_W-1:0] key;       // Active key = segmentation stack number
   } aks_out_t;

   typedef struct packed {
      logic                 valid;
      aks_int_t             kind;
      logic [AKS_LVL_W-1:0] level;
   } aks_irq_t;

endpackage : aks_pkg

// >>> tb/aks_chan_model.sv
// Partner: processor and cycle-steal channel presenting access requests.
// Assumes the bench changes the command just after a rising clk_sys edge.
`timescale 1ns/1ps
module aks_chan_model
   import aks_pkg::*;
(
   input  wire aks_req_t cmd,
   output aks_req_t      req
);
   // Only cycle-steal data carries a key from its control block;
   // elsewhere the key lines carry the inverse of the commanded key, not the commanded value
   always_comb begin
      req = cmd;
      if (cmd.acc != ACC_CS_DATA) begin
         req.cs_key = ~cmd.cs_key;
      end
   end
endmodule : aks_chan_model

// >>> tb/tb_address_key_selector.sv
// Self-checking bench for the address key selector.
// Assumes one 20 MHz clock; the bench stands in for the processor and console.
`timescale 1ns/1ps
module tb_address_key_selector;
   import aks_pkg::*;
   logic [4:0]  avs_address = '0;
   logic        avs_read = 0, avs_write = 0, clk_sys = 0, rst = 1, initial_program_load = 0, supervisor = 0;
   logic [31:0] avs_writedata = '0, avs_readdata, q, e, seed = 32'hE2D4;
   logic        avs_waitrequest, en_instr = 0, en_merge = 0, translator_off_instr = 0, xl = 0;
   logic        seg_read_only = 0, protect_check, stop_cmp_keyed, xlate_enabled, pf = 0;
   logic [1:0]  cur_level = '0;
   logic [2:0]  stop_cmp_key;
   aks_irq_t    irq_in = '0;
   aks_req_t    cmd = '0, req_in;
   aks_out_t    acc_out;
   int          err_count = 0, n_tests = 0, con = 0, lkr[4];
   // ************
   // Design and far side
   // ************
   aks_chan_model u_aks_chan_model (.cmd(cmd), .req(req_in));
   aks_selector u_aks_selector (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .initial_program_load(initial_program_load), .supervisor(supervisor), .cur_level(cur_level), .en_instr(en_instr),
      .en_merge(en_merge), .translator_off_instr(translator_off_instr), .irq_in(irq_in),
      .req_in(req_in), .seg_read_only(seg_read_only), .acc_out(acc_out),
      .protect_check(protect_check), .stop_cmp_key(stop_cmp_key),
      .stop_cmp_keyed(stop_cmp_keyed), .xlate_enabled(xlate_enabled));
   initial forever #25 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic report_and_stop;
      if (err_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      n_tests++;
      if (s !== x) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   // Bus cycle: hold the request until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask : bus
   // Model of the key choice, from the level register image
   function automatic logic [2:0] ekey(input aks_acc_t a, input int r, input logic [2:0] c);
      case (a)
         ACC_IFETCH, ACC_EXT_WORD, ACC_BR_INDIR: return r[2:0];
         ACC_OP1: return r[15] ? r[6:4] : r[10:8];
         ACC_OP2, ACC_DPC_WRITE: return r[6:4];
         ACC_CS_DATA: return c;
         ACC_CONSOLE: return con[2:0];
         default: return 3'h0;
      endcase
   endfunction : ekey
   // One access with random direction, read-only bit and state
   task automatic acc(input aks_acc_t a, input logic [1:0] l);
      logic p;
      @(posedge clk_sys);
      cmd <= '{1'b1, a, seed[3], l, seed[2:0]};
      seg_read_only <= seed[4];
      supervisor <= seed[5];
      @(negedge clk_sys);
      p = xl & ~seed[5] & seed[3] & seed[4] & a != ACC_CS_DATA & a != ACC_DCB_FETCH;
      pf |= p;
      chk("key", ekey(a, lkr[l], seed[2:0]), acc_out.key);
      chk("protect", p, protect_check);
      chk("write", seed[3] & ~p, acc_out.write); chk("valid", 1, acc_out.valid);
      seed = lfsr(seed);
   endtask : acc
   task automatic pulse(input int w);
      @(posedge clk_sys);
      cmd.valid <= 1'b0;
      if (w == 0) en_instr <= 1; else translator_off_instr <= 1;
      @(posedge clk_sys);
      en_instr <= 0;
      translator_off_instr <= 0;
      @(negedge clk_sys);
   endtask : pulse
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 0;
      bus(0, 5'h02, 0); chk("unmapped", 0, q);
      for (int l = 0; l < 4; l++) begin
         bus(0, 5'(l * 4), 0); chk("reset", 0, q);
         lkr[l] = seed & 'h8777; seed = lfsr(seed);
         bus(1, 5'(l * 4), lkr[l]); bus(0, 5'(l * 4), 0); chk("lkr", lkr[l], q);
      end
      con = seed[2:0]; bus(1, 5'h10, con); bus(1, 5'h14, ~con & 7);
      chk("stop", ~con & 7, stop_cmp_key);
      for (int x = 0; x < 2; x++) begin
         if (x == 1) begin pulse(0); xl = 1; lkr[0] &= 'h7FFF; chk("xlate", 1, xlate_enabled); end
         if (x == 1) chk("keyed", 1, stop_cmp_keyed);
         for (int r = 0; r < 4; r++) for (int a = 0; a < 10; a++) for (int l = 0; l < 4; l++)
            acc(aks_acc_t'(a), 2'(l));
      end
      @(posedge clk_sys) cur_level <= 2; en_merge <= 1; pulse(0); lkr[2] |= 'h8000;
      acc(ACC_OP1, 2); bus(0, 5'h08, 0); chk("merge", lkr[2], q);
      pulse(1); xl = 0; lkr[2] &= 'h7FFF; chk("xlate", 0, xlate_enabled);
      bus(0, 5'h08, 0); chk("off", lkr[2], q);
      bus(0, 5'h18, 0); chk("flag", pf, q[3]);
      bus(1, 5'h18, 32'h8); bus(0, 5'h18, 0); chk("clear", 0, q[3]);
      for (int k = 0; k < 8; k++) begin
         lkr[1] = 'h536; bus(1, 5'h04, 'h536); acc(ACC_OP1, 1);
         bus(0, 5'h18, 0); chk("last", 5, q & 7);
         @(posedge clk_sys) irq_in <= '{1'b1, aks_int_t'(k), 2'h1};
         @(posedge clk_sys) irq_in.valid <= 0;
         e = (k == 1 || k == 4) ? 3 : (k == 2 || k == 3) ? 5 : (k == 5) ? 6 : 0;
         bus(0, 5'h04, 0); chk("irq", e << 8, q);
      end
      @(posedge clk_sys) initial_program_load <= 1;
      @(posedge clk_sys) initial_program_load <= 0;
      for (int l = 0; l < 4; l++) begin bus(0, 5'(l * 4), 0); chk("ipl", 0, q); end
      report_and_stop();
   end
endmodule : tb_address_key_selector
